/* logic/tws_pkg.sv */
// constants, codes and carrier types of the two-wire slave block
package tws_pkg;
	// register word addresses on the plain register port
	localparam logic [1:0] ADR_OWN    = 2'h0;
	localparam logic [1:0] ADR_CTRL   = 2'h1;
	localparam logic [1:0] ADR_STATUS = 2'h2;
	localparam logic [1:0] ADR_DATA   = 2'h3;
	// control register bit positions
	localparam int BIT_FLAG  = 7;
	localparam int BIT_ACK   = 6;
	localparam int BIT_STA   = 5;
	localparam int BIT_STO   = 4;
	localparam int BIT_WC    = 3;
	localparam int BIT_EN    = 2;
	localparam int BIT_IE    = 0;
	// own address register: general call enable position
	localparam int BIT_GCE   = 0;
	// reset values
	localparam logic [7:0] RST_OWN    = 8'hFE;
	localparam logic [7:0] RST_DATA   = 8'hFF;
	localparam logic [7:0] RST_STATUS = 8'hF8;
	// slave status codes, prescaler bits zero
	localparam logic [7:0] ST_SR_OWN     = 8'h60;
	localparam logic [7:0] ST_SR_OWN_ARB = 8'h68;
	localparam logic [7:0] ST_SR_GC      = 8'h70;
	localparam logic [7:0] ST_SR_GC_ARB  = 8'h78;
	localparam logic [7:0] ST_SR_DATA_A  = 8'h80;
	localparam logic [7:0] ST_SR_DATA_N  = 8'h88;
	localparam logic [7:0] ST_GC_DATA_A  = 8'h90;
	localparam logic [7:0] ST_GC_DATA_N  = 8'h98;
	localparam logic [7:0] ST_SR_STOP    = 8'hA0;
	localparam logic [7:0] ST_ST_OWN     = 8'hA8;
	localparam logic [7:0] ST_ST_OWN_ARB = 8'hB0;
	localparam logic [7:0] ST_ST_DATA_A  = 8'hB8;
	localparam logic [7:0] ST_ST_DATA_N  = 8'hC0;
	localparam logic [7:0] ST_ST_LAST_A  = 8'hC8;
	localparam logic [7:0] ST_NO_INFO    = 8'hF8;
	localparam logic [7:0] GC_ADDRESS    = 8'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam int         SYNC_WIDTH    = 2;

	typedef enum {TWS_IDLE, TWS_ADDR, TWS_ADDR_ACK, TWS_RX_DATA, TWS_RX_ACK,
		TWS_TX_DATA, TWS_TX_ACK, TWS_IGNORE} tws_state_t;

	// conditions seen on the bus, one clk_in cycle each except the levels
	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic scl;
		logic sda;
	} tws_ev_t;
endpackage

/* logic/tws_sync.sv */
// two-flop synchronisers for the bus pins
`timescale 1ns/10ps
module tws_sync (
	input  wire logic                         clk_in,
	input  wire logic                         reset_in,
	input  wire logic [tws_pkg::SYNC_WIDTH-1:0] async_in,
	output logic      [tws_pkg::SYNC_WIDTH-1:0] sync_out
);
	logic [tws_pkg::SYNC_WIDTH-1:0] meta;

	genvar i;
	generate
		for (i = 0; i < tws_pkg::SYNC_WIDTH; i++) begin : g_bit
			// released bus idles high, so reset to one
			always_ff @(posedge clk_in) begin
				if (reset_in) begin
					meta[i]     <= 1'b1;
					sync_out[i] <= 1'b1;
				end else begin
					meta[i]     <= async_in[i];
					sync_out[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule

/* logic/tws_cond.sv */
// edge and start/stop detection on the synchronised bus lines
`timescale 1ns/10ps
module tws_cond (
	input  wire logic            clk_in,
	input  wire logic            reset_in,
	input  wire logic            scl_in,
	input  wire logic            sda_in,
	output tws_pkg::tws_ev_t     ev_out
);
	logic scl_d;
	logic sda_d;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			scl_d  <= 1'b1;
			sda_d  <= 1'b1;
			ev_out <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
		end else begin
			scl_d           <= scl_in;
			sda_d           <= sda_in;
			ev_out.scl      <= scl_in;
			ev_out.sda      <= sda_in;
			ev_out.scl_rise <= scl_in && !scl_d;
			ev_out.scl_fall <= !scl_in && scl_d;
			// data moving while the clock stays high marks a condition
			ev_out.start    <= scl_in && scl_d && sda_d && !sda_in;
			ev_out.stop     <= scl_in && scl_d && !sda_d && sda_in;
		end
	end
endmodule

/* logic/tws_slave.sv */
// two-wire slave receiver/transmitter with registers and address match
// Notes on behaviour
// [R01] 0x88: own data, NACK sent, leave addressed
// [R02] flag cleared with start: START once free
// [R03] 0x90: general call data acknowledged
// [R04] 0x98: general call data NACK, unaddressed
// [R05] stop or restart while addressed as receiver reports 0xA0
// [R06] compare address with upper seven own bits
// [R07] general call only when own bit0 set
// [R08] software sets enable and acknowledge first
// [R09] software clears start and stop at init
// [R10] read bit selects transmit, else receive
// [R11] address match sets flag and status
// [R12] arbitration lost then read reports 0xB0
// [R13] ack-enable cleared: last byte, 0xC0/0xC8
// [R14] after last byte release SDA, ignore master
// [R15] master ACK after last byte gives 0xC8
// [R16] ack-enable low hides own address
// [R17] sleep: address match still acknowledged
// [R18] wake-up holds SCL low until flag cleared
// [R19] data register may stay stale in sleep
// [R20] status prescaler bits read zero
// [R21] flag set stretches SCL low
`timescale 1ns/10ps
module tws_slave (
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic [1:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [7:0] rdata_out,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            scl_oe_out,
	output logic            sda_oe_out,
	input  wire logic       sleep_in,
	input  wire logic       arb_lost_in,
	output logic            wake_out,
	output logic            start_out
);
	////////////////////////////////////////////////////////////////////////
	logic [1:0]          pins_sync;
	tws_pkg::tws_ev_t    ev;
	tws_pkg::tws_state_t st;
	logic [7:0] own_addr;
	logic [7:0] status;
	logic [7:0] data;
	logic [7:0] shreg;
	logic [7:0] tx_shift;
	logic [3:0] cnt;
	logic       flag;
	logic       ack_en;
	logic       start_request_column;
	logic       stop_request_column;
	logic       wc;
	logic       en;
	logic       ie;
	logic       drive;
	logic       is_read;
	logic       is_gc;
	logic       ack_given;
	logic       mack;
	logic       last_byte;
	logic       start_pending;
	logic       bus_free;
	logic       wr_ctrl;
	logic       flag_clr;
	logic       own_hit;
	logic       gc_hit;
	logic       byte_done;
	logic       rx_store;

	tws_sync u_sync (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.async_in ({scl_in, sda_in}),
		.sync_out (pins_sync)
	);

	tws_cond u_cond (
		.clk_in   (clk_in),
		.reset_in (reset_in),
		.scl_in   (pins_sync[1]),
		.sda_in   (pins_sync[0]),
		.ev_out   (ev)
	);

	function automatic logic is_addressed_rx(input tws_pkg::tws_state_t s);
		return (s == tws_pkg::TWS_RX_DATA) || (s == tws_pkg::TWS_RX_ACK);
	endfunction

	assign wr_ctrl   = wr_in && (addr_in == tws_pkg::ADR_CTRL);
	assign flag_clr  = wr_ctrl && wdata_in[tws_pkg::BIT_FLAG];
	assign own_hit   = en && ack_en && (shreg[7:1] == own_addr[7:1]); // [R06] [R16] [R17]
	assign gc_hit    = en && ack_en && own_addr[tws_pkg::BIT_GCE]
		&& (shreg == tws_pkg::GC_ADDRESS); // [R07]
	assign byte_done = ev.scl_fall && (cnt == tws_pkg::BITS_PER_BYTE);
	// asleep, received bytes are not copied out; the data word goes stale
	assign rx_store  = byte_done && (st == tws_pkg::TWS_RX_DATA) && !sleep_in; // [R19]

	////////////////////////////////////////////////////////////////////////
	// software configuration
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			own_addr <= tws_pkg::RST_OWN;
			ack_en   <= 1'b0;
			start_request_column      <= 1'b0;
			stop_request_column      <= 1'b0;
			en       <= 1'b0;
			ie       <= 1'b0;
		end else begin
			if (wr_in && addr_in == tws_pkg::ADR_OWN) begin
				own_addr <= wdata_in;
			end
			if (wr_ctrl) begin
				ack_en <= wdata_in[tws_pkg::BIT_ACK];
				start_request_column    <= wdata_in[tws_pkg::BIT_STA];
				stop_request_column    <= wdata_in[tws_pkg::BIT_STO];
				en     <= wdata_in[tws_pkg::BIT_EN];
				ie     <= wdata_in[tws_pkg::BIT_IE];
			end
		end
	end

	// data word: a received byte wins over a software write in the same cycle
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			data <= tws_pkg::RST_DATA;
			wc   <= 1'b0;
		end else begin
			if (wr_in && addr_in == tws_pkg::ADR_DATA) begin
				if (flag) begin
					data <= wdata_in;
				end else begin
					wc <= 1'b1;
				end
			end
			if (wr_ctrl && !wdata_in[tws_pkg::BIT_WC]) begin
				wc <= 1'b0;
			end
			if (rx_store) begin
				data <= shreg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// slave engine, interrupt flag and status
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st        <= tws_pkg::TWS_IDLE;
			cnt       <= 4'h0;
			shreg     <= 8'h00;
			tx_shift  <= 8'hFF;
			drive     <= 1'b0;
			is_read   <= 1'b0;
			is_gc     <= 1'b0;
			ack_given <= 1'b0;
			mack      <= 1'b0;
			last_byte <= 1'b0;
			flag      <= 1'b0;
			status    <= tws_pkg::RST_STATUS;
		end else begin
			// clear first; any set below overrides it
			if (flag_clr) begin
				flag <= 1'b0;
			end
			if (flag_clr && st == tws_pkg::TWS_TX_DATA && cnt == 4'h0) begin
				tx_shift  <= data;
				drive     <= !data[7];
				last_byte <= !wdata_in[tws_pkg::BIT_ACK]; // [R13]
			end
			if (!en) begin
				st    <= tws_pkg::TWS_IDLE;
				drive <= 1'b0;
			end else if (ev.start || ev.stop) begin
				if (is_addressed_rx(st)) begin
					flag   <= 1'b1;
					status <= tws_pkg::ST_SR_STOP; // [R05]
				end
				st    <= ev.start ? tws_pkg::TWS_ADDR : tws_pkg::TWS_IDLE;
				cnt   <= 4'h0;
				drive <= 1'b0;
			end else begin
				unique case (st)
					tws_pkg::TWS_IDLE, tws_pkg::TWS_IGNORE: begin
						drive <= 1'b0; // [R14]
					end
					tws_pkg::TWS_ADDR: begin
						if (ev.scl_rise) begin
							shreg <= {shreg[6:0], ev.sda};
							cnt   <= cnt + 4'h1;
						end else if (byte_done) begin
							if (own_hit || gc_hit) begin
								st      <= tws_pkg::TWS_ADDR_ACK;
								drive   <= 1'b1;
								is_read <= own_hit && shreg[0];
								is_gc   <= !own_hit;
							end else begin
								st <= tws_pkg::TWS_IGNORE; // [R07] [R16]
							end
						end
					end
					tws_pkg::TWS_ADDR_ACK: begin
						if (ev.scl_fall) begin
							drive <= 1'b0;
							cnt   <= 4'h0;
							flag  <= 1'b1; // [R11]
							if (is_read) begin
								st     <= tws_pkg::TWS_TX_DATA; // [R10]
								status <= arb_lost_in ? tws_pkg::ST_ST_OWN_ARB // [R12]
									: tws_pkg::ST_ST_OWN;
							end else begin
								st <= tws_pkg::TWS_RX_DATA; // [R10]
								if (is_gc) begin
									status <= arb_lost_in ? tws_pkg::ST_SR_GC_ARB
										: tws_pkg::ST_SR_GC;
								end else begin
									status <= arb_lost_in ? tws_pkg::ST_SR_OWN_ARB
										: tws_pkg::ST_SR_OWN;
								end
							end
						end
					end
					tws_pkg::TWS_RX_DATA: begin
						if (ev.scl_rise) begin
							shreg <= {shreg[6:0], ev.sda};
							cnt   <= cnt + 4'h1;
						end else if (byte_done) begin
							st        <= tws_pkg::TWS_RX_ACK;
							drive     <= ack_en; // [R03]
							ack_given <= ack_en;
						end
					end
					tws_pkg::TWS_RX_ACK: begin
						if (ev.scl_fall) begin
							drive <= 1'b0;
							cnt   <= 4'h0;
							flag  <= 1'b1;
							st    <= ack_given ? tws_pkg::TWS_RX_DATA : tws_pkg::TWS_IGNORE; // [R01]
							if (is_gc) begin
								status <= ack_given ? tws_pkg::ST_GC_DATA_A // [R03]
									: tws_pkg::ST_GC_DATA_N; // [R04]
							end else begin
								status <= ack_given ? tws_pkg::ST_SR_DATA_A
									: tws_pkg::ST_SR_DATA_N; // [R01]
							end
						end
					end
					tws_pkg::TWS_TX_DATA: begin
						if (ev.scl_rise) begin
							cnt <= cnt + 4'h1;
						end else if (byte_done) begin
							st    <= tws_pkg::TWS_TX_ACK;
							drive <= 1'b0;
						end else if (ev.scl_fall && cnt != 4'h0) begin
							tx_shift <= {tx_shift[6:0], 1'b1};
							drive    <= !tx_shift[6];
						end
					end
					tws_pkg::TWS_TX_ACK: begin
						if (ev.scl_rise) begin
							mack <= !ev.sda;
						end else if (ev.scl_fall) begin
							flag <= 1'b1;
							cnt  <= 4'h0;
							if (last_byte) begin
								// unaddressed: the master now clocks in ones
								st     <= tws_pkg::TWS_IGNORE; // [R14]
								status <= mack ? tws_pkg::ST_ST_LAST_A // [R15]
									: tws_pkg::ST_ST_DATA_N; // [R13]
							end else if (mack) begin
								st     <= tws_pkg::TWS_TX_DATA;
								status <= tws_pkg::ST_ST_DATA_A;
							end else begin
								st     <= tws_pkg::TWS_IGNORE;
								status <= tws_pkg::ST_ST_DATA_N;
							end
						end
					end
				endcase
			end
		end
	end

	// stretching is the flag itself; a slow wake-up blocks the bus that long
	assign scl_oe_out = flag; // [R18] [R21]
	assign sda_oe_out = drive;

	////////////////////////////////////////////////////////////////////////
	// pending START towards the master section, and wake request
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			start_pending <= 1'b0;
			bus_free      <= 1'b1;
			start_out     <= 1'b0;
			wake_out      <= 1'b0;
		end else begin
			if (ev.stop) begin
				bus_free <= 1'b1;
			end else if (ev.start) begin
				bus_free <= 1'b0;
			end
			if (flag_clr && wdata_in[tws_pkg::BIT_STA]
				&& (st == tws_pkg::TWS_IGNORE || st == tws_pkg::TWS_IDLE)) begin
				start_pending <= 1'b1; // [R02]
			end else if (wr_ctrl && !wdata_in[tws_pkg::BIT_STA]) begin
				start_pending <= 1'b0;
			end
			start_out <= start_pending && bus_free && !ev.start; // [R02]
			wake_out  <= sleep_in && flag; // [R17] [R18]
		end
	end

	// register read port, answer one cycle after the strobe
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			rdata_out <= 8'h00;
		end else if (rd_in) begin
			unique case (addr_in)
				tws_pkg::ADR_OWN:    rdata_out <= own_addr;
				tws_pkg::ADR_CTRL:   rdata_out <= {flag, ack_en, start_request_column, stop_request_column, wc, en, 1'b0, ie};
				tws_pkg::ADR_STATUS: rdata_out <= flag ? {status[7:3], 3'h0} // [R20]
					: tws_pkg::ST_NO_INFO;
				tws_pkg::ADR_DATA:   rdata_out <= data;
			endcase
		end else begin
			rdata_out <= 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	a_status_prescale: assert property ((rd_in && addr_in == tws_pkg::ADR_STATUS) // [R20]
		|=> rdata_out[2:0] == 3'h0) else $error("status prescaler bits not zero");
	a_own_nack_leave: assert property ((ev.scl_fall && st == tws_pkg::TWS_RX_ACK // [R01]
		&& !ack_given && !is_gc && en && !ev.start && !ev.stop)
		|=> st == tws_pkg::TWS_IGNORE && status == tws_pkg::ST_SR_DATA_N && flag)
		else $error("own data NACK did not give 0x88");
	a_gc_data_ack: assert property ((ev.scl_fall && st == tws_pkg::TWS_RX_ACK // [R03]
		&& ack_given && is_gc && en && !ev.start && !ev.stop)
		|=> status == tws_pkg::ST_GC_DATA_A && st == tws_pkg::TWS_RX_DATA)
		else $error("general call data ACK did not give 0x90");
	a_gc_data_nack: assert property ((ev.scl_fall && st == tws_pkg::TWS_RX_ACK // [R04]
		&& !ack_given && is_gc && en && !ev.start && !ev.stop)
		|=> status == tws_pkg::ST_GC_DATA_N && st == tws_pkg::TWS_IGNORE)
		else $error("general call data NACK did not give 0x98");
	a_stop_addressed: assert property ((ev.stop && en && is_addressed_rx(st)) // [R05]
		|=> flag && status == tws_pkg::ST_SR_STOP && st == tws_pkg::TWS_IDLE)
		else $error("stop while addressed did not give 0xA0");
	a_addr_match: assert property ((byte_done && st == tws_pkg::TWS_ADDR // [R06]
		&& own_hit && !ev.start && !ev.stop)
		|=> st == tws_pkg::TWS_ADDR_ACK && sda_oe_out) else $error("own address not acked");
	a_gc_ignore: assert property ((byte_done && st == tws_pkg::TWS_ADDR && en // [R07]
		&& !own_addr[tws_pkg::BIT_GCE] && !own_hit && !ev.start && !ev.stop)
		|=> st == tws_pkg::TWS_IGNORE [*2]) else $error("general call not ignored");
	a_dir_select: assert property ((ev.scl_fall && st == tws_pkg::TWS_ADDR_ACK // [R10]
		&& en && !ev.start && !ev.stop)
		|=> flag && ((st == tws_pkg::TWS_TX_DATA) == is_read)) // [R11]
		else $error("direction or flag wrong after address");
	a_arb_read: assert property ((ev.scl_fall && st == tws_pkg::TWS_ADDR_ACK && is_read // [R12]
		&& arb_lost_in && en && !ev.start && !ev.stop)
		|=> status == tws_pkg::ST_ST_OWN_ARB) else $error("lost arbitration read not 0xB0");
	a_last_byte: assert property ((ev.scl_fall && st == tws_pkg::TWS_TX_ACK // [R13]
		&& last_byte && en && !ev.start && !ev.stop)
		|=> st == tws_pkg::TWS_IGNORE && status == (mack ? tws_pkg::ST_ST_LAST_A // [R15]
		: tws_pkg::ST_ST_DATA_N)) else $error("last byte end status wrong");
	a_ignore_release: assert property ((st == tws_pkg::TWS_IGNORE) [*2] // [R14]
		|-> !sda_oe_out) else $error("SDA driven while not addressed");
	a_ack_gate: assert property ((byte_done && st == tws_pkg::TWS_ADDR && !ack_en // [R16]
		&& !ev.start && !ev.stop && en) |=> st == tws_pkg::TWS_IGNORE)
		else $error("address answered with ack-enable low");
	a_sleep_stale: assert property ((rx_store == 1'b0 && !wr_in && sleep_in) // [R19]
		|=> $stable(data)) else $error("data word changed while asleep");
	a_stretch_flag: assert property ((flag && !flag_clr) |=> scl_oe_out) // [R21]
		else $error("SCL released while flag set");
	a_wake_hold: assert property ((sleep_in && flag && !flag_clr) |=> wake_out && scl_oe_out) // [R18]
		else $error("wake-up not held");
	a_start_free: assert property ((start_pending && bus_free && !ev.start) // [R02]
		|=> start_out) else $error("pending START not issued on free bus");

	c_rx_byte:  cover property (ev.scl_fall && st == tws_pkg::TWS_RX_ACK && ack_given);
	c_tx_last:  cover property (ev.scl_fall && st == tws_pkg::TWS_TX_ACK && last_byte && mack);
	c_gc_match: cover property (byte_done && st == tws_pkg::TWS_ADDR && gc_hit && !own_hit);
	c_wake:     cover property (sleep_in && flag);
endmodule

/* verif/tws_master_model.sv */
// bus master model driving the two-wire lines of the slave bench
`timescale 1ns/10ps
module tws_master_model (
	input  wire logic scl_in,
	input  wire logic sda_in,
	output logic      scl_low_out,
	output logic      sda_low_out
);
	initial begin
		scl_low_out = 1'b0;
		sda_low_out = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// one 80 ns bit; sda moves mid-low so it is never read as start or stop
	// low phase is 50 ns: the slave moves sda up to 40 ns after a fall, and a
	// later move would land while scl is high and read as a false condition
	task automatic bit_io(input logic b, output logic s);
		#20 sda_low_out = !b;
		#30 scl_low_out = 1'b0;
		// the slave may stretch the low phase
		wait (scl_in);
		#30 s = sda_in;
		scl_low_out = 1'b1;
	endtask
	task automatic start();
		#20 sda_low_out = 1'b0;
		#20 scl_low_out = 1'b0;
		wait (scl_in);
		#40 sda_low_out = 1'b1;
		#40 scl_low_out = 1'b1;
	endtask
	task automatic stop();
		#20 sda_low_out = 1'b1;
		#20 scl_low_out = 1'b0;
		wait (scl_in);
		#40 sda_low_out = 1'b0;
		#40;
	endtask
	// after the ack bit scl stays low a while so the slave can stretch first
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, ack);
		#40;
	endtask
	task automatic rd_byte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, d[i]);
		bit_io(nack, s);
		#40;
	endtask
endmodule

/* verif/tb_two_wire_slave_rx_tx_control.sv */
// self-checking bench of the two-wire slave block
`timescale 1ns/10ps
module tb_two_wire_slave_rx_tx_control;
	localparam logic [1:0] OW = tws_pkg::ADR_OWN;
	localparam logic [1:0] CT = tws_pkg::ADR_CTRL;
	localparam logic [1:0] SR = tws_pkg::ADR_STATUS;
	localparam logic [1:0] DT = tws_pkg::ADR_DATA;
	logic       clk_in;
	logic       reset_in;
	logic [1:0] addr_in;
	logic [7:0] wdata_in;
	logic       wr_in;
	logic       rd_in;
	logic [7:0] rdata_out;
	logic       scl_oe_out;
	logic       sda_oe_out;
	logic       sleep_in;
	logic       arb_lost_in;
	logic       wake_out;
	logic       start_out;
	logic       m_scl;
	logic       m_sda;
	logic       ack;
	logic [7:0] b;
	int         n_mismatch;
	int         tests_run;
	int         cyc;
	// both lines have pull-ups: released means high
	wire        scl_w = !(m_scl || scl_oe_out);
	wire        sda_w = !(m_sda || sda_oe_out);

	tws_slave u_dut (
		.clk_in      (clk_in),
		.reset_in    (reset_in),
		.addr_in     (addr_in),
		.wdata_in    (wdata_in),
		.wr_in       (wr_in),
		.rd_in       (rd_in),
		.rdata_out   (rdata_out),
		.scl_in      (scl_w),
		.sda_in      (sda_w),
		.scl_oe_out  (scl_oe_out),
		.sda_oe_out  (sda_oe_out),
		.sleep_in    (sleep_in),
		.arb_lost_in (arb_lost_in),
		.wake_out    (wake_out),
		.start_out   (start_out)
	);
	tws_master_model u_mst (
		.scl_in      (scl_w),
		.sda_in      (sda_w),
		.scl_low_out (m_scl),
		.sda_low_out (m_sda)
	);
	////////////////////////////////////////////////////////////////
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// the whole run needs a few thousand cycles
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			test_done();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		chk(rdata_out, exp);
	endtask
	// flag also holds scl low; bounded wait, then status
	task automatic flag(input logic [7:0] st);
		int n;
		n = 0;
		while (scl_oe_out !== 1'b1 && n < 400) begin
			@(posedge clk_in);
			n++;
		end
		chk({7'h0, scl_w}, 8'h00);
		rd(SR, st);
	endtask
	task automatic mw(input logic [7:0] d, input logic a);
		u_mst.wr_byte(d, ack);
		chk({7'h0, ack}, {7'h0, a});
	endtask
	task automatic mr(input logic nack, input logic [7:0] exp);
		u_mst.rd_byte(nack, b);
		chk(b, exp);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		reset_in = 1'b1;
		addr_in = 2'h0;
		wdata_in = 8'h00;
		wr_in = 1'b0;
		rd_in = 1'b0;
		sleep_in = 1'b0;
		arb_lost_in = 1'b0;
		n_mismatch = 0;
		tests_run = 0;
		cyc = 0;
		repeat (10) @(posedge clk_in);
		reset_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		rd(OW, 8'hFE);
		rd(CT, 8'h00);
		rd(SR, 8'hF8);
		rd(DT, 8'hFF);
		wr(OW, 8'hA4);
		wr(CT, 8'h44);
		// data write without the flag is a collision
		wr(DT, 8'h12);
		rd(CT, 8'h4C);
		wr(CT, 8'h44);
		// own address, receive, then refuse a byte
		u_mst.start();
		mw(8'hA4, 1'b0);
		flag(8'h60);
		wr(CT, 8'hC4);
		mw(8'h3C, 1'b0);
		flag(8'h80);
		rd(DT, 8'h3C);
		wr(CT, 8'h84);
		mw(8'h55, 1'b1);
		flag(8'h88);
		wr(CT, 8'hE4);
		u_mst.stop();
		// stop reaches start_out after the pin pipeline
		repeat (8) @(posedge clk_in);
		chk({7'h0, start_out}, 8'h01);
		wr(CT, 8'h04);
		repeat (2) @(posedge clk_in);
		chk({7'h0, start_out}, 8'h00);
		// ack enable low hides the own address
		u_mst.start();
		mw(8'hA4, 1'b1);
		u_mst.stop();
		wr(CT, 8'h44);
		u_mst.start();
		mw(8'hA4, 1'b0);
		flag(8'h60);
		wr(CT, 8'hC4);
		u_mst.stop();
		flag(8'hA0);
		wr(CT, 8'hC4);
		// general call, off then on
		u_mst.start();
		mw(8'h00, 1'b1);
		u_mst.stop();
		wr(OW, 8'hA5);
		u_mst.start();
		mw(8'h00, 1'b0);
		flag(8'h70);
		wr(CT, 8'hC4);
		mw(8'h81, 1'b0);
		flag(8'h90);
		wr(CT, 8'h84);
		mw(8'h7E, 1'b1);
		flag(8'h98);
		wr(CT, 8'hC4);
		u_mst.stop();
		// transmit: last byte acked by master, then ones
		u_mst.start();
		mw(8'hA5, 1'b0);
		flag(8'hA8);
		wr(DT, 8'h96);
		wr(CT, 8'hC4);
		mr(1'b0, 8'h96);
		flag(8'hB8);
		wr(DT, 8'h5A);
		wr(CT, 8'h84);
		mr(1'b0, 8'h5A);
		flag(8'hC8);
		wr(CT, 8'hC4);
		mr(1'b0, 8'hFF);
		mr(1'b1, 8'hFF);
		u_mst.stop();
		// lost arbitration, then last byte refused
		@(posedge clk_in);
		arb_lost_in <= 1'b1;
		u_mst.start();
		mw(8'hA5, 1'b0);
		flag(8'hB0);
		@(posedge clk_in);
		arb_lost_in <= 1'b0;
		wr(DT, 8'hC3);
		wr(CT, 8'h84);
		mr(1'b1, 8'hC3);
		flag(8'hC0);
		wr(CT, 8'hC4);
		u_mst.stop();
		// deep sleep: match still acked, data reg left alone
		@(posedge clk_in);
		sleep_in <= 1'b1;
		u_mst.start();
		mw(8'hA4, 1'b0);
		flag(8'h60);
		chk({7'h0, wake_out}, 8'h01);
		wr(DT, 8'hA7);
		wr(CT, 8'hC4);
		mw(8'h99, 1'b0);
		flag(8'h80);
		rd(DT, 8'hA7);
		@(posedge clk_in);
		sleep_in <= 1'b0;
		wr(CT, 8'hC4);
		u_mst.stop();
		flag(8'hA0);
		wr(CT, 8'hC4);
		test_done();
	end
endmodule
